// >>> pobrs_pkg.sv
package pobrs_pkg;
  // timing
  localparam int          CLK_HZ            = 50_000_000;
  localparam int          POWERUP_DELAY_TIMER_MS           = 64;
  localparam int          POWERUP_DELAY_TIMER_CYC          = (CLK_HZ / 1000) * POWERUP_DELAY_TIMER_MS;
  localparam int          BOR_MIN_NS        = 2000;
  localparam int          BOR_MIN_CYC       = (BOR_MIN_NS + 19) / 20;
  localparam int          RESTART_CYC       = 10;
  localparam int          CNT_W             = 32;
  // brownout modes
  localparam logic [1:0]  BMODE_ON          = 2'h3;
  localparam logic [1:0]  BMODE_SLEEP_OFF   = 2'h2;
  localparam logic [1:0]  BMODE_SOFT        = 2'h1;
  localparam logic [1:0]  BMODE_OFF         = 2'h0;
  // register map
  localparam logic [11:0] ADDR_CTRL         = 12'h000;
  localparam logic [11:0] ADDR_CAUSE        = 12'h004;
  localparam logic [11:0] ADDR_MASK         = 12'h008;
  localparam logic [11:0] ADDR_STAT         = 12'h00c;
  // control fields
  localparam int          CTRL_SOFT_EN      = 0;
  // cause / mask fields
  localparam int          EV_POR            = 0;
  localparam int          EV_BOR            = 1;
  localparam int          EV_OVF            = 2;
  localparam int          EV_UNF            = 3;
  localparam int          EV_W              = 4;
  // status fields
  localparam int          ST_READY          = 0;
  localparam int          ST_HOLD           = 1;
  localparam int          ST_BOR_ACT        = 2;

  typedef struct packed {
    logic [1:0] brownout_mode_cfg;
    logic       powerup_delay_enable_n;
    logic       brownout_level_select;
    logic       stack_reset_enable;
  } pobrs_cfg_s;

  typedef struct packed {
    logic por_low;
    logic brownout_below;
    logic brownout_circuit_ready;
  } pobrs_mon_s;
endpackage

// >>> pobrs_sync.sv
`timescale 1ns/10ps
module pobrs_sync
  import pobrs_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // pobrs_sync

// >>> pobrs_filt.sv
`timescale 1ns/10ps
module pobrs_filt
  import pobrs_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic arm,
  input  wire logic below,
  output logic      trip
);
  logic [CNT_W-1:0] cnt_r;

  // a dip must last more than the minimum duration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      trip  <= 1'b0;
    end else if (!arm || !below) begin
      cnt_r <= '0;
      trip  <= 1'b0;
    end else if (cnt_r < CNT_W'(BOR_MIN_CYC)) begin
      cnt_r <= cnt_r + 1'b1;
    end else begin
      trip  <= 1'b1;
    end
  end
endmodule // pobrs_filt

// >>> pobrs_top.sv
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/10ps
// Summary of operation
// R1: low supply on power-on monitor keeps device reset held.
// R2: active brownout reporting below threshold holds device in reset.
// R3: after power-on or brownout, delay timer holds reset for 64 ms.
// R4: delay timer enabled only when its active-low enable bit is clear.
// R5: delay count starts once power-on and brownout conditions both clear.
// R6: two-bit mode field: 11 on, 10 off in sleep, 01 software, 00 off.
// R7: always-on waits ready and supply at start, stays on in sleep.
// R8: off-in-sleep disables in sleep, start and wake wait for ready.
// R9: software mode: enable bit switches detection, start-up does not wait.
// R10: software mode protects once ready; readable ready flag mirrors circuit.
// R11: in software mode sleep does not change protection.
// R12: forced-on modes see ready before release, so no extra delay.
// R13: one config bit chooses the brownout threshold level.
// R14: short dips ignored; reset only if low longer than minimum duration.
// R15: stack overflow or underflow sets cause flag and resets when enabled.
// R16: external reset released after delay expiry restarts after 10 cycles.
// R17: reset output is OR of all sources until every one releases.
// R18: supply monitor inputs are synchronised before use.
module pobrs_top
  import pobrs_pkg::*;
#(
  parameter int POWERUP_DELAY_TIMER_CYCLES = POWERUP_DELAY_TIMER_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire pobrs_cfg_s  cfg,
  input  wire pobrs_mon_s  mon,
  input  wire logic        sleep_active,
  input  wire logic        external_reset_pin_n,
  input  wire logic        stack_overflow_evt,
  input  wire logic        stack_underflow_evt,
  output logic             device_reset_hold,
  output logic             brownout_level_sel_out,
  output logic             brownout_circuit_en,
  output logic             irq
);
  typedef enum logic [1:0] {ST_HOLDING, ST_DELAY, ST_WAITPIN, ST_RUN} pobrs_state_e;

  pobrs_state_e      state_r;
  pobrs_mon_s        mon_s;
  logic [CNT_W-1:0]  cnt_r;
  logic              soft_brownout_enable_r;
  logic [EV_W-1:0]   cause_r;
  logic [EV_W-1:0]   stat_r;
  logic [EV_W-1:0]   mask_r;
  logic              stack_rst_r;
  logic              brownout_active;
  logic              brownout_hold;
  logic              brownout_ready_flag;
  logic              wait_ready;
  logic              trip;
  logic              src_hold;
  logic              pin_sync;
  logic              wr_en;
  logic              rd_en;
  logic [EV_W-1:0]   ev;
  logic              sleep_q_r;
  logic              wake;

  // monitor inputs crossed into pclk domain
  pobrs_sync #(.W(3)) u_sync ( // R18
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({mon.por_low, mon.brownout_below, mon.brownout_circuit_ready}),
    .q       ({mon_s.por_low, mon_s.brownout_below, mon_s.brownout_circuit_ready})
  );

  pobrs_sync #(.W(1)) u_pin (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (external_reset_pin_n),
    .q       (pin_sync)
  );

  assign brownout_ready_flag = mon_s.brownout_circuit_ready; // R10

  // mode decode
  always_comb begin
    unique case (cfg.brownout_mode_cfg) // R6
      BMODE_ON:        brownout_active = 1'b1; // R7
      BMODE_SLEEP_OFF: brownout_active = !sleep_active; // R8
      BMODE_SOFT:      brownout_active = soft_brownout_enable_r; // R9 R11
      BMODE_OFF:       brownout_active = 1'b0;
    endcase
  end

  // start-up waits on ready in forced modes; wake waits only in off-in-sleep
  assign wait_ready = (cfg.brownout_mode_cfg == BMODE_ON) ||
                      (cfg.brownout_mode_cfg == BMODE_SLEEP_OFF); // R7 R8 R12

  pobrs_filt u_filt (
    .pclk    (pclk),
    .presetn (presetn),
    .arm     (brownout_active && brownout_ready_flag), // R10
    .below   (mon_s.brownout_below),
    .trip    (trip) // R14
  );

  assign brownout_hold = trip; // R2
  assign src_hold = mon_s.por_low || brownout_hold; // R1 R2

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_q_r <= 1'b0;
    end else begin
      sleep_q_r <= sleep_active;
    end
  end
  assign wake = sleep_q_r && !sleep_active;

  // sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_HOLDING;
      cnt_r   <= '0;
    end else if (src_hold || stack_rst_r) begin
      state_r <= ST_HOLDING; // R17
      cnt_r   <= '0;
    end else begin
      unique case (state_r)
        ST_HOLDING: begin
          if (!wait_ready || (brownout_ready_flag && !mon_s.brownout_below)) begin
            cnt_r   <= '0;
            state_r <= cfg.powerup_delay_enable_n ? ST_WAITPIN : ST_DELAY; // R4 R5
          end
        end
        ST_DELAY: begin
          if (cnt_r >= CNT_W'(POWERUP_DELAY_TIMER_CYCLES - 1)) begin // R3
            cnt_r   <= '0;
            state_r <= ST_WAITPIN;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        ST_WAITPIN: begin
          if (!pin_sync) begin
            cnt_r <= '0;
          end else if (cnt_r >= CNT_W'(RESTART_CYC - 1)) begin // R16
            state_r <= ST_RUN;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        ST_RUN: begin
          if (!pin_sync) begin
            cnt_r   <= '0;
            state_r <= ST_WAITPIN;
          end else if (wake && cfg.brownout_mode_cfg == BMODE_SLEEP_OFF &&
                       !brownout_ready_flag) begin
            state_r <= ST_HOLDING; // R8
          end
        end
      endcase
    end
  end

  // stack fault reset pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_rst_r <= 1'b0;
    end else begin
      stack_rst_r <= cfg.stack_reset_enable &&
                     (stack_overflow_evt || stack_underflow_evt); // R15
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      device_reset_hold      <= 1'b1;
      brownout_level_sel_out <= 1'b0;
      brownout_circuit_en    <= 1'b0;
    end else begin
      device_reset_hold      <= src_hold || stack_rst_r || (state_r != ST_RUN); // R17
      brownout_level_sel_out <= cfg.brownout_level_select; // R13
      brownout_circuit_en    <= brownout_active;
    end
  end

  // apb
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  assign ev = {stack_underflow_evt, stack_overflow_evt, brownout_hold, mon_s.por_low};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_brownout_enable_r <= 1'b0;
      mask_r                 <= '0;
    end else if (wr_en && paddr == ADDR_CTRL) begin
      soft_brownout_enable_r <= pwdata[CTRL_SOFT_EN]; // R9
    end else if (wr_en && paddr == ADDR_MASK) begin
      mask_r <= pwdata[EV_W-1:0];
    end
  end

  // cause flags: set wins over write-one-to-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_r <= '0;
      cause_r[EV_POR] <= 1'b1;
    end else begin
      for (int i = 0; i < EV_W; i++) begin
        if (ev[i]) begin
          cause_r[i] <= 1'b1; // R15
        end else if (wr_en && paddr == ADDR_CAUSE && pwdata[i]) begin
          cause_r[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(cause_r & mask_r);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= '0;
    end else begin
      stat_r <= '0;
      stat_r[ST_READY]   <= brownout_ready_flag; // R10
      stat_r[ST_HOLD]    <= device_reset_hold;
      stat_r[ST_BOR_ACT] <= brownout_active;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (rd_en) begin
        prdata <= '0;
        unique case (paddr)
          ADDR_CTRL:  prdata[CTRL_SOFT_EN] <= soft_brownout_enable_r;
          ADDR_CAUSE: prdata[EV_W-1:0] <= cause_r;
          ADDR_MASK:  prdata[EV_W-1:0] <= mask_r;
          ADDR_STAT:  prdata[EV_W-1:0] <= stat_r;
          default:    pslverr <= 1'b1;
        endcase
      end else if (psel && !penable && !(paddr inside {ADDR_CTRL, ADDR_CAUSE, ADDR_MASK, ADDR_STAT})) begin
        pslverr <= 1'b1;
      end
    end
  end

  stack_rst_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cfg.stack_reset_enable && stack_overflow_evt) |-> ##2 device_reset_hold) // R15
    else $error("stack fault did not hold reset");

  por_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    mon_s.por_low |=> device_reset_hold) // R1
    else $error("reset released during low supply");

  sequence s_trip; trip; endsequence
  bor_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_trip |=> device_reset_hold) // R2
    else $error("brownout did not hold reset");

  off_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    cfg.brownout_mode_cfg == BMODE_OFF |-> !brownout_active) // R6
    else $error("brownout active in off mode");

  pin_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_WAITPIN && !pin_sync) |=> state_r != ST_RUN) // R16
    else $error("run entered while pin low");

  sleep_cut_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cfg.brownout_mode_cfg == BMODE_SLEEP_OFF && sleep_active) |-> !brownout_active) // R8
    else $error("brownout active in sleep");

  run_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    device_reset_hold && $past(state_r) == ST_RUN && !$past(src_hold)
    |-> $past(stack_rst_r)) // R17
    else $error("unexplained reset hold");

  ready_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 stat_r[ST_READY] == $past(brownout_ready_flag)) // R10
    else $error("ready flag mismatch");
endmodule // pobrs_top

// >>> testbench.sv
`timescale 1ns/10ps
module testbench
  import pobrs_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        e, sleep_active, external_reset_pin_n, stack_overflow_evt, stack_underflow_evt;
  logic        device_reset_hold, brownout_level_sel_out, brownout_circuit_en;
  pobrs_cfg_s  cfg;
  pobrs_mon_s  mon;
  int          bad_count, comparisons;

  pobrs_top #(.POWERUP_DELAY_TIMER_CYCLES(50)) u_pobrs_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cfg(cfg), .mon(mon), .sleep_active(sleep_active),
    .external_reset_pin_n(external_reset_pin_n), .stack_overflow_evt(stack_overflow_evt),
    .stack_underflow_evt(stack_underflow_evt), .device_reset_hold(device_reset_hold),
    .brownout_level_sel_out(brownout_level_sel_out),
    .brownout_circuit_en(brownout_circuit_en), .irq(irq)
  );

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task finish_test();
    if (bad_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // one apb transfer, held until pready is seen
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    // idle edge keeps a following call from re-driving psel in the same time step
    @(posedge pclk);
    if (n >= 20) begin
      bad_count++;
      finish_test();
    end
  endtask

  task wait_hold(input logic v, input int lim);
    int n;
    n = 0;
    while (device_reset_hold !== v && n < lim) begin
      n++;
      @(posedge pclk);
    end
    chk(device_reset_hold, v);
    if (n >= lim) finish_test();
  endtask

  task por_pulse();
    mon.por_low <= 1'b1;
    wait_hold(1'b1, 10);
    mon.por_low <= 1'b0;
  endtask

  initial begin
    bad_count = 0; comparisons = 0;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; sleep_active = 1'b0; external_reset_pin_n = 1'b1;
    stack_overflow_evt = 1'b0; stack_underflow_evt = 1'b0;
    cfg = '{brownout_mode_cfg: BMODE_OFF, powerup_delay_enable_n: 1'b0,
            brownout_level_select: 1'b0, stack_reset_enable: 1'b1};
    mon = '{por_low: 1'b1, brownout_below: 1'b0, brownout_circuit_ready: 1'b1};
    cyc(3);
    chk(device_reset_hold, 1'b1);
    presetn <= 1'b1;
    cyc(1);
    apb(0, ADDR_CAUSE, 0); chk(q & 32'h1, 32'h1);
    apb(1, ADDR_CTRL, 32'h1); apb(0, ADDR_CTRL, 0); chk(q & 32'h1, 32'h1);
    apb(1, ADDR_CTRL, 32'h0); apb(0, 12'h010, 0); chk(e, 1'b1);
    cyc(10); chk(device_reset_hold, 1'b1);
    mon.por_low <= 1'b0;
    cyc(30); chk(device_reset_hold, 1'b1);
    wait_hold(1'b0, 100);
    apb(1, ADDR_MASK, 32'hf); cyc(1); chk(irq, 1'b1);
    apb(1, ADDR_CAUSE, 32'hf); cyc(2); chk(irq, 1'b0);
    // delay disabled: release well before the delay count could end
    cfg.powerup_delay_enable_n <= 1'b1;
    por_pulse();
    wait_hold(1'b0, 30);
    cfg.brownout_level_select <= 1'b1;
    cyc(3); chk(brownout_level_sel_out, 1'b1);
    cfg.brownout_mode_cfg <= BMODE_ON;
    cyc(5); chk(brownout_circuit_en, 1'b1);
    sleep_active <= 1'b1;
    cyc(5); chk(brownout_circuit_en, 1'b1);
    sleep_active <= 1'b0;
    apb(1, ADDR_CAUSE, 32'hf);
    mon.brownout_below <= 1'b1; cyc(50); mon.brownout_below <= 1'b0;
    cyc(5); chk(device_reset_hold, 1'b0);
    mon.brownout_below <= 1'b1; cyc(130); chk(device_reset_hold, 1'b1);
    apb(0, ADDR_CAUSE, 0); chk(q & 32'h2, 32'h2); chk(irq, 1'b1);
    mon.brownout_below <= 1'b0;
    wait_hold(1'b0, 40);
    apb(1, ADDR_CAUSE, 32'hf);
    cfg.brownout_mode_cfg <= BMODE_SLEEP_OFF; sleep_active <= 1'b1;
    cyc(5); chk(brownout_circuit_en, 1'b0);
    sleep_active <= 1'b0;
    cyc(5); chk(brownout_circuit_en, 1'b1);
    cfg.brownout_mode_cfg <= BMODE_SOFT;
    cyc(5); chk(brownout_circuit_en, 1'b0);
    apb(1, ADDR_CTRL, 32'h1);
    cyc(5); chk(brownout_circuit_en, 1'b1);
    sleep_active <= 1'b1;
    cyc(5); chk(brownout_circuit_en, 1'b1);
    sleep_active <= 1'b0; mon.brownout_circuit_ready <= 1'b0;
    cyc(5); apb(0, ADDR_STAT, 0); chk(q & 32'h1, 32'h0);
    mon.brownout_circuit_ready <= 1'b1;
    cyc(5); apb(0, ADDR_STAT, 0); chk(q & 32'h1, 32'h1);
    cfg.brownout_mode_cfg <= BMODE_OFF;
    cyc(5); chk(brownout_circuit_en, 1'b0);
    stack_overflow_evt <= 1'b1; cyc(1); stack_overflow_evt <= 1'b0;
    wait_hold(1'b1, 10);
    apb(0, ADDR_CAUSE, 0); chk(q & 32'h4, 32'h4);
    wait_hold(1'b0, 40);
    apb(1, ADDR_CAUSE, 32'hf); cfg.stack_reset_enable <= 1'b0;
    stack_underflow_evt <= 1'b1; cyc(1); stack_underflow_evt <= 1'b0;
    cyc(10); chk(device_reset_hold, 1'b0);
    apb(0, ADDR_CAUSE, 0); chk(q & 32'h8, 32'h8); chk(irq, 1'b1);
    apb(1, ADDR_MASK, 32'h0); cyc(2); chk(irq, 1'b0);
    // external pin held past the delay, then released
    cfg.powerup_delay_enable_n <= 1'b0; external_reset_pin_n <= 1'b0;
    por_pulse();
    cyc(80); chk(device_reset_hold, 1'b1);
    external_reset_pin_n <= 1'b1;
    cyc(8); chk(device_reset_hold, 1'b1);
    wait_hold(1'b0, 20);
    finish_test();
  end

  initial begin
    #1ms;
    bad_count++;
    finish_test();
  end
endmodule // testbench
